// ==== design/dfal_alert_pin.sv ====
// open-drain alert pin driver with polarity and pin read-back
`timescale 1ns/1ps
module dfal_alert_pin
   import dfal_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rstn,
   input  wire logic alert_next,
   input  wire logic output_polarity,
   input  wire logic alert_in,
   output logic      alert_out,
   output logic      alert_oe_n,
   output logic      alert_pin_level
);

   logic sync_1;
   logic sync_2;

   // open drain only ever pulls low; the pad resistor makes the high level
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         alert_out  <= 1'b0;
         alert_oe_n <= 1'b1;
      end else begin
         alert_out  <= 1'b0;
         alert_oe_n <= alert_next ~^ output_polarity;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync_1          <= 1'b1;
         sync_2          <= 1'b1;
         alert_pin_level <= 1'b1;
      end else begin
         sync_1          <= alert_in;
         sync_2          <= sync_1;
         alert_pin_level <= sync_2;
      end
   end

endmodule : dfal_alert_pin

// ==== design/dfal_limit_cmp.sv ====
// limit comparators for one conversion result
`timescale 1ns/1ps
module dfal_limit_cmp
   import dfal_pkg::*;
(
   input  wire dfal_sample_type  sample,
   input  wire dfal_limits_type  limits,
   input  wire logic [15:0]      shunt_high_threshold,
   input  wire logic [15:0]      shunt_low_threshold,
   input  wire logic             shunt_range_select,
   output logic [NUM_LIMITS-1:0] cond
);

   logic [21:0] high_scaled;
   logic [21:0] low_scaled;

   // narrow range: quarter span, so the threshold lsb is four times finer
   always_comb begin
      if (shunt_range_select) begin
         high_scaled = {{2{shunt_high_threshold[15]}}, shunt_high_threshold, 4'h0};
         low_scaled  = {{2{shunt_low_threshold[15]}}, shunt_low_threshold, 4'h0};
      end else begin
         high_scaled = {shunt_high_threshold, 6'h00};
         low_scaled  = {shunt_low_threshold, 6'h00};
      end
   end

   always_comb begin
      cond                  = '0;
      cond[LIM_TEMP]        = $signed(sample.temp) > $signed(limits.temp_limit);
      // signed: a negative high threshold trips on a zero result
      cond[LIM_SHUNT_OVER]  = $signed(sample.shunt) > $signed(high_scaled);
      cond[LIM_SHUNT_UNDER] = $signed(sample.shunt) < $signed(low_scaled);
      cond[LIM_BUS_OVER]    = sample.bus[19:4] > {1'b0, limits.bus_high};
      cond[LIM_BUS_UNDER]   = sample.bus[19:4] < {1'b0, limits.bus_low};
      cond[LIM_POWER]       = sample.power[23:8] > limits.power_limit;
   end

endmodule : dfal_limit_cmp

// ==== design/dfal_pkg.sv ====
// shared constants and carriers for the diagnostic flag and alert logic
package dfal_pkg;

   localparam int          ADDR_W           = 6;
   localparam int          DATA_W           = 16;

   // register addresses on the serial register port
   localparam logic [5:0]  ADDR_DIAG        = 6'h0B;
   localparam logic [5:0]  ADDR_SHUNT_HIGH  = 6'h0C;
   localparam logic [5:0]  ADDR_SHUNT_LOW   = 6'h0D;

   // reset values
   localparam logic [15:0] DIAG_RESET       = 16'h0001;
   localparam logic [15:0] SHUNT_HIGH_RESET = 16'h7FFF;
   localparam logic [15:0] SHUNT_LOW_RESET  = 16'h8000;

   // diagnostic register field positions
   localparam int          BIT_LATCH        = 15;
   localparam int          BIT_CONV_READY_ON_OUTPUT         = 14;
   localparam int          BIT_AVG          = 13;
   localparam int          BIT_POL          = 12;
   localparam int          BIT_ENERGY_OF    = 11;
   localparam int          BIT_CHARGE_OF    = 10;
   localparam int          BIT_MATH_OF      = 9;
   localparam int          BIT_RESERVED     = 8;
   localparam int          LIMIT_MSB        = 7;
   localparam int          LIMIT_LSB        = 2;
   localparam int          BIT_CONV_DONE    = 1;
   localparam int          BIT_TRIM_OK      = 0;
   localparam int          NUM_LIMITS       = 6;

   // index of each limit inside the limit vector (bit 7 down to bit 2)
   localparam int          LIM_TEMP         = 5;
   localparam int          LIM_SHUNT_OVER   = 4;
   localparam int          LIM_SHUNT_UNDER  = 3;
   localparam int          LIM_BUS_OVER     = 2;
   localparam int          LIM_BUS_UNDER    = 1;
   localparam int          LIM_POWER        = 0;

   // shunt threshold lsb in 78.125 nV sample units: 5 uV wide, 1.25 uV narrow
   localparam int          SHUNT_WIDE_SHIFT   = 6;
   localparam int          SHUNT_NARROW_SHIFT = 4;

   // shunt sample in fixed 78.125 nV units; bus and power as in result registers
   typedef struct packed {
      logic        is_avg;
      logic [21:0] shunt;
      logic [19:0] bus;
      logic [15:0] temp;
      logic [23:0] power;
   } dfal_sample_type;

   typedef struct packed {
      logic [14:0] bus_high;
      logic [14:0] bus_low;
      logic [15:0] temp_limit;
      logic [15:0] power_limit;
   } dfal_limits_type;

endpackage : dfal_pkg

// ==== design/dfal_top.sv ====
// diagnostic flags, shunt thresholds and alert generation
//
// Contract
// - transparent mode: alert and flag go idle once the fault is gone
// - latched mode: alert and flag stay active until diagnostic register read
// - conversion-ready-on-alert set: conversion done flag drives alert
// - averaged select picks raw results or only completed averages for comparison
// - polarity bit: 0 active-low open drain, 1 active-high open drain
// - energy overflow flag set on overflow, cleared by energy result read
// - charge overflow flag set on overflow, cleared by charge result read
// - arithmetic overflow flag clears only on triggered conversion or accumulator clear
// - bit 8 reads zero, writes ignored
// - temperature over-limit flag; latched mode read clears it
// - shunt over-limit flag; latched mode read clears it
// - shunt under-limit flag; latched mode read clears it
// - bus over-limit flag; latched mode read clears it
// - bus under-limit flag; latched mode read clears it
// - power over-limit flag; latched mode read clears it
// - conversion done flag; latched read or triggered conversion start clears it
// - trim memory status resets to 1, goes 0 on checksum error
// - shunt high compare signed; negative threshold trips on zero result
// - shunt high threshold 16-bit signed, reset 7FFF, range-dependent scale
// - shunt low threshold 16-bit signed, reset 8000, same scale
// - range select: 0 wide range, 1 narrow range quarter span
// - temperature limit compared directly with die temperature result
`timescale 1ns/1ps
module dfal_top
   import dfal_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rstn,
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   output logic      [DATA_W-1:0]   reg_rdata,
   input  wire logic                sample_valid,
   input  wire dfal_sample_type     sample,
   input  wire dfal_limits_type     limits,
   input  wire logic                shunt_range_select,
   input  wire logic                conv_start,
   input  wire logic                conv_done,
   input  wire logic                energy_overflow,
   input  wire logic                energy_read,
   input  wire logic                charge_overflow,
   input  wire logic                charge_read,
   input  wire logic                math_overflow,
   input  wire logic                accum_clear_cmd,
   input  wire logic                trim_checksum_error,
   input  wire logic                alert_in,
   output logic                     alert_out,
   output logic                     alert_oe_n,
   output logic                     alert_active,
   output logic                     alert_pin_level
);

   // configuration bits of the diagnostic register
   logic                  latch_select;
   logic                  conv_ready_on_output;
   logic                  averaged_compare_select;
   logic                  output_polarity;

   // status bits
   logic                  energy_accum_overflow;
   logic                  charge_accum_overflow;
   logic                  arith_overflow_flag;
   logic [NUM_LIMITS-1:0] limit_flags;
   logic                  conv_done_flag;
   logic                  trim_memory_ok;

   logic [15:0]           shunt_high_threshold;
   logic [15:0]           shunt_low_threshold;

   logic [NUM_LIMITS-1:0] cond;
   logic [NUM_LIMITS-1:0] next_limit_flags;
   logic                  next_conv_done_flag;
   logic                  next_alert;
   logic                  diag_rd;
   logic                  diag_wr;
   logic                  eval;
   logic [DATA_W-1:0]     diag_value;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] target);
      return addr == target;
   endfunction : addr_hit

   assign diag_rd = reg_rd && addr_hit(reg_addr, ADDR_DIAG);
   assign diag_wr = reg_wr && addr_hit(reg_addr, ADDR_DIAG);

   // averaged mode skips raw results, so the alert waits for the average
   assign eval = sample_valid && (!averaged_compare_select || sample.is_avg);

   dfal_limit_cmp u_cmp (
      .sample               (sample),
      .limits               (limits),
      .shunt_high_threshold (shunt_high_threshold),
      .shunt_low_threshold  (shunt_low_threshold),
      .shunt_range_select   (shunt_range_select),
      .cond                 (cond)
   );

   // ---- configuration bits
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         latch_select            <= DIAG_RESET[BIT_LATCH];
         conv_ready_on_output    <= DIAG_RESET[BIT_CONV_READY_ON_OUTPUT];
         averaged_compare_select <= DIAG_RESET[BIT_AVG];
         output_polarity         <= DIAG_RESET[BIT_POL];
      end else if (diag_wr) begin
         latch_select            <= reg_wdata[BIT_LATCH];
         conv_ready_on_output    <= reg_wdata[BIT_CONV_READY_ON_OUTPUT];
         averaged_compare_select <= reg_wdata[BIT_AVG];
         output_polarity         <= reg_wdata[BIT_POL];
      end
   end

   // ---- shunt thresholds
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         shunt_high_threshold <= SHUNT_HIGH_RESET;
         shunt_low_threshold  <= SHUNT_LOW_RESET;
      end else if (reg_wr) begin
         if (addr_hit(reg_addr, ADDR_SHUNT_HIGH)) begin
            shunt_high_threshold <= reg_wdata;
         end
         if (addr_hit(reg_addr, ADDR_SHUNT_LOW)) begin
            shunt_low_threshold <= reg_wdata;
         end
      end
   end

   // ---- limit and conversion flags; a new result beats a read or write
   always_comb begin
      next_limit_flags = limit_flags;
      if (diag_wr) begin
         next_limit_flags = reg_wdata[LIMIT_MSB:LIMIT_LSB];
      end
      if (latch_select && diag_rd) begin
         next_limit_flags = '0;
      end
      if (eval) begin
         if (latch_select) begin
            next_limit_flags = next_limit_flags | cond;
         end else begin
            next_limit_flags = cond;
         end
      end
   end

   always_comb begin
      next_conv_done_flag = conv_done_flag;
      if (diag_wr) begin
         next_conv_done_flag = reg_wdata[BIT_CONV_DONE];
      end
      if (conv_start || (latch_select && diag_rd)) begin
         next_conv_done_flag = 1'b0;
      end
      if (conv_done) begin
         next_conv_done_flag = 1'b1;
      end
   end

   // alert follows the flags in the same edge they change
   assign next_alert = (|next_limit_flags)
                       || (conv_ready_on_output && next_conv_done_flag);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         limit_flags    <= DIAG_RESET[LIMIT_MSB:LIMIT_LSB];
         conv_done_flag <= DIAG_RESET[BIT_CONV_DONE];
         alert_active   <= 1'b0;
      end else begin
         limit_flags    <= next_limit_flags;
         conv_done_flag <= next_conv_done_flag;
         alert_active   <= next_alert;
      end
   end

   // ---- accumulator and arithmetic overflow; the set wins over the clear
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         energy_accum_overflow <= DIAG_RESET[BIT_ENERGY_OF];
         charge_accum_overflow <= DIAG_RESET[BIT_CHARGE_OF];
      end else begin
         if (energy_overflow) begin
            energy_accum_overflow <= 1'b1;
         end else if (energy_read) begin
            energy_accum_overflow <= 1'b0;
         end
         if (charge_overflow) begin
            charge_accum_overflow <= 1'b1;
         end else if (charge_read) begin
            charge_accum_overflow <= 1'b0;
         end
      end
   end

   // reads of the diagnostic register deliberately leave this one alone
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         arith_overflow_flag <= DIAG_RESET[BIT_MATH_OF];
      end else if (math_overflow) begin
         arith_overflow_flag <= 1'b1;
      end else if (conv_start || accum_clear_cmd) begin
         arith_overflow_flag <= 1'b0;
      end
   end

   // ---- trim memory status; a checksum error wins over a host write
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         trim_memory_ok <= DIAG_RESET[BIT_TRIM_OK];
      end else if (trim_checksum_error) begin
         trim_memory_ok <= 1'b0;
      end else if (diag_wr) begin
         trim_memory_ok <= reg_wdata[BIT_TRIM_OK];
      end
   end

   // ---- read path; data shows the state before any read-clear
   always_comb begin
      diag_value                          = '0;
      diag_value[BIT_LATCH]               = latch_select;
      diag_value[BIT_CONV_READY_ON_OUTPUT]                = conv_ready_on_output;
      diag_value[BIT_AVG]                 = averaged_compare_select;
      diag_value[BIT_POL]                 = output_polarity;
      diag_value[BIT_ENERGY_OF]           = energy_accum_overflow;
      diag_value[BIT_CHARGE_OF]           = charge_accum_overflow;
      diag_value[BIT_MATH_OF]             = arith_overflow_flag;
      diag_value[LIMIT_MSB:LIMIT_LSB]     = limit_flags;
      diag_value[BIT_CONV_DONE]           = conv_done_flag;
      diag_value[BIT_TRIM_OK]             = trim_memory_ok;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_DIAG:       reg_rdata <= diag_value;
            ADDR_SHUNT_HIGH: reg_rdata <= shunt_high_threshold;
            ADDR_SHUNT_LOW:  reg_rdata <= shunt_low_threshold;
            default:         reg_rdata <= '0;
         endcase
      end
   end

   dfal_alert_pin u_pin (
      .core_clk        (core_clk),
      .rstn            (rstn),
      .alert_next      (next_alert),
      .output_polarity (output_polarity),
      .alert_in        (alert_in),
      .alert_out       (alert_out),
      .alert_oe_n      (alert_oe_n),
      .alert_pin_level (alert_pin_level)
   );

   // ---- checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   a_reserved_zero: assert property (
      reg_rd && addr_hit(reg_addr, ADDR_DIAG) |=> reg_rdata[BIT_RESERVED] == 1'b0)
      else $error("reserved diagnostic bit read as one");

   a_transparent_follow: assert property (
      eval && !latch_select |=> limit_flags == $past(cond))
      else $error("transparent flags do not follow the comparison");

   a_latch_hold: assert property (
      latch_select && !diag_rd && !diag_wr
      |=> (limit_flags & $past(limit_flags)) == $past(limit_flags))
      else $error("latched flag dropped without a read");

   a_read_clear: assert property (
      latch_select && diag_rd && !eval && !diag_wr |=> limit_flags == '0)
      else $error("latched flags not cleared by read");

   a_conv_ready_on_output_alert: assert property (
      conv_done && conv_ready_on_output && !diag_wr
      |=> alert_active && alert_oe_n == output_polarity)
      else $error("conversion done did not raise the alert");

   a_avg_gate: assert property (
      sample_valid && averaged_compare_select && !sample.is_avg && !diag_wr && !diag_rd
      |=> limit_flags == $past(limit_flags))
      else $error("raw result compared in averaged mode");

   a_pin_sense: assert property (
      ##1 alert_oe_n == (alert_active ~^ $past(output_polarity)))
      else $error("alert pin drive does not match polarity");

   a_energy_flag: assert property (
      energy_overflow |=> energy_accum_overflow ##1 (energy_accum_overflow || $past(energy_read)))
      else $error("energy overflow flag not set");

   a_math_hold: assert property (
      arith_overflow_flag && !conv_start && !accum_clear_cmd |=> arith_overflow_flag)
      else $error("arithmetic overflow flag cleared without cause");

   a_trim_error: assert property (
      trim_checksum_error |=> !trim_memory_ok)
      else $error("checksum error did not clear trim status");

   a_shunt_zero: assert property (
      eval && sample.shunt == '0 && shunt_high_threshold[15]
      |=> limit_flags[LIM_SHUNT_OVER])
      else $error("zero shunt result missed negative high threshold");

   a_charge_flag: assert property (
      charge_overflow |=> charge_accum_overflow ##1 (charge_accum_overflow || $past(charge_read)))
      else $error("charge overflow flag not set");

   a_energy_clear: assert property (
      energy_read && !energy_overflow |=> !energy_accum_overflow)
      else $error("energy overflow flag not cleared by result read");

   a_charge_clear: assert property (
      charge_read && !charge_overflow |=> !charge_accum_overflow)
      else $error("charge overflow flag not cleared by result read");

   a_conv_done_set: assert property (
      conv_done |=> conv_done_flag)
      else $error("conversion done flag not set");

   a_conv_start_clear: assert property (
      conv_start && !conv_done |=> !conv_done_flag)
      else $error("conversion done flag survived a triggered conversion");

   a_math_set: assert property (
      math_overflow |=> arith_overflow_flag)
      else $error("arithmetic overflow flag not set");

   a_latched_alert: assert property (
      latch_select && alert_active && !diag_rd && !diag_wr && !conv_start |=> alert_active)
      else $error("latched alert dropped without a read");

   a_transparent_idle: assert property (
      eval && !latch_select && cond == '0 && !conv_ready_on_output |=> !alert_active)
      else $error("transparent alert stayed active after the fault cleared");

endmodule : dfal_top

// ==== sim/dfal_host_model.sv ====
// host processor model: register port master and alert pad pull-up
`timescale 1ns/1ps
module dfal_host_model
   import dfal_pkg::*;
(
   input  wire logic         core_clk,
   output logic [ADDR_W-1:0] reg_addr,
   output logic              reg_wr,
   output logic              reg_rd,
   output logic [DATA_W-1:0] reg_wdata,
   input  wire logic         alert_oe_n,
   output logic              alert_in
);
   initial begin
      reg_addr  = '0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_wdata = '0;
   end
   // pad has a pull-up: released means high
   assign alert_in = alert_oe_n ? 1'b1 : 1'b0;
   // idle edge first, so back-to-back strobes never glitch in one time step
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      #1;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(posedge core_clk);
      #1;
      reg_wr    = 1'b0;
      // data not left at its last value once released
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge core_clk);
      #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge core_clk);
      #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;
   endtask : rd
endmodule : dfal_host_model

// ==== sim/test_diag_flag_alert_logic.sv ====
// self-checking bench for the diagnostic flag and alert logic
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_diag_flag_alert_logic;
   import dfal_pkg::*;
   logic              core_clk;
   logic              rstn;
   logic [ADDR_W-1:0] reg_addr;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic              sample_valid;
   dfal_sample_type   sample;
   dfal_limits_type   limits;
   logic              range_sel;
   logic [7:0]        ev;
   logic              trim_err;
   logic              alert_in;
   logic              alert_oe_n;
   logic              alert_out;
   logic              alert_active;
   logic              alert_pin_level;
   logic              rd_pend;
   logic [DATA_W-1:0] exp_q[$];
   logic [DATA_W-1:0] exp_v;
   logic [DATA_W-1:0] r;
   int                mismatches;
   int                num_checks;
   // event pulse masks for ev
   localparam logic [7:0] E_START = 8'h80, E_DONE = 8'h40, E_EOF = 8'h20, E_ERD = 8'h10;
   localparam logic [7:0] E_COF = 8'h08, E_CRD = 8'h04, E_MOF = 8'h02, E_ACLR = 8'h01;

   dfal_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .alert_oe_n(alert_oe_n), .alert_in(alert_in));

   dfal_top uut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sample_valid(sample_valid), .sample(sample), .limits(limits),
      .shunt_range_select(range_sel), .conv_start(ev[7]), .conv_done(ev[6]),
      .energy_overflow(ev[5]), .energy_read(ev[4]), .charge_overflow(ev[3]),
      .charge_read(ev[2]), .math_overflow(ev[1]), .accum_clear_cmd(ev[0]),
      .trim_checksum_error(trim_err), .alert_in(alert_in), .alert_out(alert_out),
      .alert_oe_n(alert_oe_n), .alert_active(alert_active),
      .alert_pin_level(alert_pin_level));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task pulse(input logic [7:0] m);
      cyc(1);
      ev = m;
      cyc(1);
      ev = '0;
   endtask : pulse
   task samp(input logic a, input logic [21:0] s, input logic [19:0] b,
             input logic [15:0] t, input logic [23:0] p);
      cyc(1);
      sample       = {a, s, b, t, p};
      sample_valid = 1'b1;
      cyc(1);
      sample_valid = 1'b0;
   endtask : samp
   // every limit comfortably inside its thresholds
   task nrm(input logic a);
      samp(a, 22'h0, 20'h320, 16'h0, 24'h0);
   endtask : nrm
   // expected read data is noted before the request goes out
   task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask : rd
   task tend(input string s);
      $display("test %s done", s);
   endtask : tend
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   always @(posedge core_clk) rd_pend <= reg_rd;
   // read data stands from the edge after the strobe until the next read
   always @(negedge core_clk) begin
      if (rd_pend === 1'b1) begin
         if (exp_q.size() == 0) begin
            mismatches++;
            $display("[ERR] %0t read data with nothing expected", $time);
         end else begin
            exp_v = exp_q.pop_front();
            `CHK(reg_rdata, exp_v)
         end
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      end_sim();
   end

   initial begin
      rstn = 1'b0;
      sample_valid = 1'b0;
      sample = '0;
      range_sel = 1'b0;
      ev = '0;
      trim_err = 1'b0;
      limits = {15'h0064, 15'h000A, 16'h1000, 16'h0064};
      mismatches = 0;
      num_checks = 0;
      void'($urandom(738));
      repeat (20) @(posedge core_clk);
      #1;
      rstn = 1'b1;
      rd(ADDR_DIAG, 16'h0001);
      rd(ADDR_SHUNT_HIGH, 16'h7FFF);
      rd(ADDR_SHUNT_LOW, 16'h8000);
      rd(6'h00, 16'h0000);
      `CHK(alert_oe_n, 1'b1)
      r = 16'($urandom);
      host.wr(ADDR_SHUNT_HIGH, r);
      rd(ADDR_SHUNT_HIGH, r);
      host.wr(ADDR_SHUNT_LOW, ~r);
      rd(ADDR_SHUNT_LOW, ~r);
      host.wr(ADDR_DIAG, 16'h0F01);
      rd(ADDR_DIAG, 16'h0001);
      host.wr(ADDR_SHUNT_HIGH, 16'h0010);
      host.wr(ADDR_SHUNT_LOW, 16'hFFF0);
      nrm(1'b0);
      tend("registers");
      samp(1'b0, 22'h401 + 22'($urandom % 64), 20'h320, 16'h0, 24'h0);
      `CHK(alert_active, 1'b1)
      cyc(1);
      `CHK(alert_oe_n, 1'b0)
      rd(ADDR_DIAG, 16'h0041);
      nrm(1'b0);
      `CHK(alert_active, 1'b0)
      rd(ADDR_DIAG, 16'h0001);
      tend("transparent");
      host.wr(ADDR_DIAG, 16'h8001);
      cyc(1);
      for (int k = 0; k < NUM_LIMITS; k++) begin
         case (k)
            0: samp(1'b0, 22'h0, 20'h320, 16'h0, 24'h006500);
            1: samp(1'b0, 22'h0, 20'h090, 16'h0, 24'h0);
            2: samp(1'b0, 22'h0, 20'h650, 16'h0, 24'h0);
            3: samp(1'b0, 22'h3FFBFF, 20'h320, 16'h0, 24'h0);
            4: samp(1'b0, 22'h401, 20'h320, 16'h0, 24'h0);
            default: samp(1'b0, 22'h0, 20'h320, 16'h1001, 24'h0);
         endcase
         nrm(1'b0);
         `CHK(alert_active, 1'b1)
         rd(ADDR_DIAG, 16'h8001 | (16'h0004 << k));
         `CHK(alert_active, 1'b0)
         rd(ADDR_DIAG, 16'h8001);
      end
      tend("latched");
      host.wr(ADDR_DIAG, 16'h1001);
      cyc(3);
      `CHK(alert_oe_n, 1'b0)
      `CHK(alert_out, 1'b0)
      cyc(4);
      `CHK(alert_pin_level, 1'b0)
      samp(1'b0, 22'h401, 20'h320, 16'h0, 24'h0);
      cyc(1);
      `CHK(alert_oe_n, 1'b1)
      nrm(1'b0);
      host.wr(ADDR_DIAG, 16'h0001);
      cyc(6);
      `CHK(alert_pin_level, 1'b1)
      tend("polarity");
      host.wr(ADDR_DIAG, 16'h4001);
      cyc(2);
      pulse(E_DONE);
      `CHK(alert_active, 1'b1)
      rd(ADDR_DIAG, 16'h4003);
      pulse(E_START);
      `CHK(alert_active, 1'b0)
      rd(ADDR_DIAG, 16'h4001);
      host.wr(ADDR_DIAG, 16'h8001);
      cyc(2);
      pulse(E_DONE);
      `CHK(alert_active, 1'b0)
      rd(ADDR_DIAG, 16'h8003);
      rd(ADDR_DIAG, 16'h8001);
      tend("conversion");
      host.wr(ADDR_DIAG, 16'h2001);
      cyc(2);
      samp(1'b0, 22'h401, 20'h320, 16'h0, 24'h0);
      `CHK(alert_active, 1'b0)
      samp(1'b1, 22'h401, 20'h320, 16'h0, 24'h0);
      `CHK(alert_active, 1'b1)
      nrm(1'b1);
      `CHK(alert_active, 1'b0)
      host.wr(ADDR_DIAG, 16'h0001);
      tend("averaged");
      for (int i = 0; i < 2; i++) begin
         pulse(i == 0 ? E_EOF : E_COF);
         rd(ADDR_DIAG, i == 0 ? 16'h0801 : 16'h0401);
         pulse(i == 0 ? E_ERD : E_CRD);
         rd(ADDR_DIAG, 16'h0001);
      end
      pulse(E_MOF);
      rd(ADDR_DIAG, 16'h0201);
      rd(ADDR_DIAG, 16'h0201);
      pulse(E_START);
      rd(ADDR_DIAG, 16'h0001);
      pulse(E_MOF);
      pulse(E_ACLR);
      rd(ADDR_DIAG, 16'h0001);
      tend("overflow");
      host.wr(ADDR_SHUNT_HIGH, 16'hFFFF);
      nrm(1'b0);
      `CHK(alert_active, 1'b1)
      host.wr(ADDR_SHUNT_HIGH, 16'h0010);
      range_sel = 1'b1;
      samp(1'b0, 22'h101, 20'h320, 16'h0, 24'h0);
      `CHK(alert_active, 1'b1)
      range_sel = 1'b0;
      samp(1'b0, 22'h101, 20'h320, 16'h0, 24'h0);
      `CHK(alert_active, 1'b0)
      tend("shunt scale");
      trim_err = 1'b1;
      cyc(1);
      trim_err = 1'b0;
      rd(ADDR_DIAG, 16'h0000);
      cyc(2);
      `CHK(exp_q.size(), 0)
      tend("trim");
      end_sim();
   end
endmodule : test_diag_flag_alert_logic
